// File: verilog/wwd_pkg.sv
`default_nettype none
package wwd_pkg;
	// Register byte offsets
	localparam logic [11:0] OFS_RESTART = 12'h000;
	localparam logic [11:0] OFS_MODE = 12'h004;
	localparam logic [11:0] OFS_STATUS = 12'h008;
	localparam logic [11:0] OFS_IRQ_MASK = 12'h00c;
	localparam logic [11:0] OFS_IRQ_STAT = 12'h010;
	localparam logic [11:0] OFS_COUNT = 12'h014;
	// Restart control fields
	localparam int KEY_MSB = 31;
	localparam int KEY_LSB = 24;
	localparam logic [7:0] RESTART_KEY = 8'ha5;
	localparam int RESTART_BIT = 0;
	// Mode register fields
	localparam int RELOAD_MSB = 11;
	localparam int RELOAD_LSB = 0;
	localparam int FIEN_BIT = 12;
	localparam int RSTEN_BIT = 13;
	localparam int PROC_BIT = 14;
	localparam int DIS_BIT = 15;
	localparam int DELTA_MSB = 27;
	localparam int DELTA_LSB = 16;
	localparam int DBGHLT_BIT = 28;
	localparam int IDLEHLT_BIT = 29;
	localparam logic [31:0] MODE_RESET = 32'h3fff2fff;
	localparam logic [31:0] MODE_USED = 32'h3fffffff;
	// Status fields
	localparam int UNF_BIT = 0;
	localparam int ERR_BIT = 1;
	// Event interrupt bits: underflow, window error
	localparam int EVT_W = 2;
	localparam logic [1:0] EVT_MASK_RESET = 2'h0;
	// Timing
	localparam int PRESCALE_DIV = 128;
	localparam int CNT_W = 12;
endpackage : wwd_pkg
`default_nettype wire

// File: verilog/wwd_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
// Divides the slow clock enable by a fixed ratio; synchronous restart
module wwd_prescaler #(
	parameter int DIV = wwd_pkg::PRESCALE_DIV
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic slow_en,
	input wire logic hold,
	input wire logic restart,
	output logic tick
);
	localparam int W = $clog2(DIV);
	localparam logic [W-1:0] LAST = W'(DIV - 1);
	logic [W-1:0] count;

	// Restart wins so a fresh period always starts from zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= '0;
		end else if (restart) begin
			count <= '0;
		end else if (slow_en && !hold) begin
			count <= (count == LAST) ? '0 : count + W'(1);
		end
	end

	assign tick = slow_en && !hold && !restart && (count == LAST);
endmodule : wwd_prescaler
`default_nettype wire

// File: verilog/wwd_top.sv
`timescale 1ns/1ps
`default_nettype none
module wwd_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic slow_clk_en,
	input wire logic debug_state,
	input wire logic idle_state,
	output logic fault_irq,
	output logic wdt_fault,
	output logic fault_proc_only,
	output logic irq
);
	////////////////////////////////////////////////////////////////////////////////
	// Bus decode
	logic wr_acc;
	logic rd_acc;
	logic hit_restart;
	logic hit_mode;
	logic hit_status;
	logic hit_mask;
	logic hit_istat;
	logic hit_count;
	logic mapped;

	assign wr_acc = psel && penable && pwrite;
	assign rd_acc = psel && penable && !pwrite;
	assign hit_restart = (paddr == wwd_pkg::OFS_RESTART);
	assign hit_mode = (paddr == wwd_pkg::OFS_MODE);
	assign hit_status = (paddr == wwd_pkg::OFS_STATUS);
	assign hit_mask = (paddr == wwd_pkg::OFS_IRQ_MASK);
	assign hit_istat = (paddr == wwd_pkg::OFS_IRQ_STAT);
	assign hit_count = (paddr == wwd_pkg::OFS_COUNT);
	assign mapped = hit_restart || hit_mode || hit_status || hit_mask || hit_istat
		|| hit_count;
	// Zero wait states; unmapped offsets answer with an error
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;

	////////////////////////////////////////////////////////////////////////////////
	// Mode register
	logic [31:0] mode;
	logic mode_locked;
	logic mode_wr;
	logic [wwd_pkg::CNT_W-1:0] reload_value;
	logic [wwd_pkg::CNT_W-1:0] window_delta;
	logic fault_irq_enable;
	logic fault_reset_enable;
	logic processor_only_reset;
	logic timer_disable;
	logic debug_halt;
	logic idle_halt;

	// Only the first full-word write lands; a partial strobe does not spend the single write
	assign mode_wr = wr_acc && hit_mode && !mode_locked && (pstrb == 4'hf);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode <= wwd_pkg::MODE_RESET;
			mode_locked <= 1'b0;
		end else if (mode_wr) begin
			mode <= pwdata & wwd_pkg::MODE_USED;
			mode_locked <= 1'b1;
		end
	end

	assign reload_value = mode[wwd_pkg::RELOAD_MSB:wwd_pkg::RELOAD_LSB];
	assign window_delta = mode[wwd_pkg::DELTA_MSB:wwd_pkg::DELTA_LSB];
	assign fault_irq_enable = mode[wwd_pkg::FIEN_BIT];
	assign fault_reset_enable = mode[wwd_pkg::RSTEN_BIT];
	assign processor_only_reset = mode[wwd_pkg::PROC_BIT];
	assign timer_disable = mode[wwd_pkg::DIS_BIT];
	assign debug_halt = mode[wwd_pkg::DBGHLT_BIT];
	assign idle_halt = mode[wwd_pkg::IDLEHLT_BIT];

	////////////////////////////////////////////////////////////////////////////////
	// Restart request and window check
	logic key_ok;
	logic restart_request;
	logic [wwd_pkg::CNT_W-1:0] count;
	logic in_window;
	logic restart_ok;
	logic window_err;

	// A wrong key discards the whole write, including the restart bit
	assign key_ok = (pwdata[wwd_pkg::KEY_MSB:wwd_pkg::KEY_LSB] == wwd_pkg::RESTART_KEY);
	assign restart_request = wr_acc && hit_restart && key_ok
		&& pwdata[wwd_pkg::RESTART_BIT];
	assign in_window = (count <= window_delta);
	// The window check applies even while disabled
	assign restart_ok = restart_request && in_window;
	assign window_err = restart_request && !in_window;

	////////////////////////////////////////////////////////////////////////////////
	// Prescaler and down counter
	logic halted;
	logic tick;
	logic underflow;

	assign halted = timer_disable
		|| (debug_halt && debug_state)
		|| (idle_halt && idle_state);

	wwd_prescaler #(
		.DIV(wwd_pkg::PRESCALE_DIV)
	) u_prescaler (
		.pclk(pclk),
		.presetn(presetn),
		.slow_en(slow_clk_en),
		.hold(halted),
		.restart(restart_ok || mode_wr),
		.tick(tick)
	);

	// Underflow is the tick that finds the counter already at zero
	assign underflow = tick && (count == '0);

	// Reload has priority over a tick in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= wwd_pkg::MODE_RESET[wwd_pkg::RELOAD_MSB:wwd_pkg::RELOAD_LSB];
		end else if (mode_wr) begin
			count <= pwdata[wwd_pkg::RELOAD_MSB:wwd_pkg::RELOAD_LSB];
		end else if (restart_ok) begin
			count <= reload_value;
		end else if (underflow) begin
			count <= reload_value;
		end else if (tick) begin
			count <= count - wwd_pkg::CNT_W'(1);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Sticky status flags
	logic underflow_flag;
	logic window_error_flag;
	logic status_rd;

	assign status_rd = rd_acc && hit_status;

	// A new event in the reading cycle survives the clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			underflow_flag <= 1'b0;
			window_error_flag <= 1'b0;
		end else begin
			underflow_flag <= underflow || (underflow_flag && !status_rd);
			window_error_flag <= window_err || (window_error_flag && !status_rd);
		end
	end

	// fault_irq and wdt_fault follow the flags so a status read drops them
	assign fault_irq = fault_irq_enable && (underflow_flag || window_error_flag);
	assign wdt_fault = fault_reset_enable && (underflow_flag || window_error_flag);
	assign fault_proc_only = processor_only_reset;

	////////////////////////////////////////////////////////////////////////////////
	// Event interrupt: sticky, write one to clear, masked
	logic [wwd_pkg::EVT_W-1:0] evt_stat;
	logic [wwd_pkg::EVT_W-1:0] evt_mask;
	logic [wwd_pkg::EVT_W-1:0] evt_in;
	logic [wwd_pkg::EVT_W-1:0] evt_clr;

	assign evt_in = {window_err, underflow};
	assign evt_clr = (wr_acc && hit_istat) ? pwdata[wwd_pkg::EVT_W-1:0] : '0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			evt_stat <= '0;
		end else begin
			evt_stat <= evt_in | (evt_stat & ~evt_clr);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			evt_mask <= wwd_pkg::EVT_MASK_RESET;
		end else if (wr_acc && hit_mask) begin
			evt_mask <= pwdata[wwd_pkg::EVT_W-1:0];
		end
	end

	assign irq = |(evt_stat & evt_mask);

	////////////////////////////////////////////////////////////////////////////////
	// Read data, registered on the setup cycle so it stands with pready
	logic [31:0] next_prdata;

	always_comb begin
		next_prdata = 32'h00000000;
		if (hit_mode) begin
			next_prdata = mode;
		end else if (hit_status) begin
			next_prdata[wwd_pkg::UNF_BIT] = underflow_flag;
			next_prdata[wwd_pkg::ERR_BIT] = window_error_flag;
		end else if (hit_mask) begin
			next_prdata[wwd_pkg::EVT_W-1:0] = evt_mask;
		end else if (hit_istat) begin
			next_prdata[wwd_pkg::EVT_W-1:0] = evt_stat;
		end else if (hit_count) begin
			next_prdata[wwd_pkg::CNT_W-1:0] = count;
		end
	end

	// Data captured at setup so it is valid during the single access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (psel && !penable && !pwrite) begin
			prdata <= next_prdata;
		end
	end
endmodule : wwd_top
`default_nettype wire

// File: verification/wwd_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// Port-level watch on the watchdog
module wwd_checker (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic fault_irq,
	input wire logic wdt_fault,
	input wire logic fault_proc_only,
	input wire logic irq
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Access phase and status read decode
	wire logic acc = psel && penable;
	wire logic st_rd = acc && !pwrite && paddr == wwd_pkg::OFS_STATUS;
	wire logic cr_wr = acc && pwrite && paddr == wwd_pkg::OFS_RESTART;
	// A first mode write may legally change the enables while a flag stands
	wire logic md_wr = acc && pwrite && paddr == wwd_pkg::OFS_MODE;
	////////////////////////////////////////////////////////////////
	pready_high_a: assert property (pready) else $error("pready low");
	err_phase_a: assert property (pslverr |-> acc) else $error("pslverr outside access");
	unmapped_err_a: assert property (acc && paddr == 12'h020 |-> pslverr)
		else $error("no pslverr");
	fault_hold_a: assert property (wdt_fault && !st_rd && !md_wr |=> wdt_fault)
		else $error("fault dropped");
	irq_hold_a: assert property (fault_irq && !st_rd && !md_wr |=> fault_irq)
		else $error("irq dropped");
	read_clear_a: assert property (st_rd |=> !fault_irq && !wdt_fault)
		else $error("not cleared");
	key_guard_a: assert property (cr_wr && pwdata[31:24] != 8'ha5
		|=> $stable(wdt_fault)) else $error("bad key acted");
	scope_set_a: assert property ($changed(fault_proc_only) |-> $past(acc && pwrite))
		else $error("scope moved");
	cover property ($rose(wdt_fault));
	cover property ($rose(irq));
	cover property (acc && pslverr);
endmodule : wwd_checker
bind wwd_top wwd_checker i_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
	.fault_irq(fault_irq), .wdt_fault(wdt_fault), .fault_proc_only(fault_proc_only), .irq(irq));
`default_nettype wire

// File: verification/wwd_partner.sv
`timescale 1ns/1ps
`default_nettype none
module wwd_partner (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic wdt_fault,
	input wire logic fault_proc_only,
	output logic slow_clk_en,
	output logic [7:0] proc_rsts,
	output logic [7:0] sys_rsts
);
	logic last;
	// Slow clock pulse every second cycle keeps runs short
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) slow_clk_en <= 1'h0;
		else slow_clk_en <= !slow_clk_en;
	end
	// Reset controller counts each new request by its scope
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last <= 1'h0;
			proc_rsts <= 8'h0;
			sys_rsts <= 8'h0;
		end else begin
			last <= wdt_fault;
			if (wdt_fault && !last && fault_proc_only) proc_rsts <= proc_rsts + 8'h1;
			if (wdt_fault && !last && !fault_proc_only) sys_rsts <= sys_rsts + 8'h1;
		end
	end
endmodule : wwd_partner
`default_nettype wire

// File: verification/wwd_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
module wwd_top_bench;
	logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic debug_state = 1'h0, idle_state = 1'h0, err;
	logic [11:0] paddr = 12'h0;
	logic [3:0] pstrb = 4'hf;
	logic [31:0] pwdata = 32'h0, rd, m;
	logic [31:0] cfg [3] = '{32'h1001_0003, 32'h2001_0003, 32'h0001_8003};
	wire logic [31:0] prdata;
	wire logic pready, pslverr, slow_clk_en, fault_irq, wdt_fault, fault_proc_only, irq;
	wire logic [7:0] proc_rsts, sys_rsts;
	int miscompares = 0, check_count = 0, seed = 40919, i;
	wwd_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .slow_clk_en(slow_clk_en), .debug_state(debug_state),
		.idle_state(idle_state), .fault_irq(fault_irq), .wdt_fault(wdt_fault),
		.fault_proc_only(fault_proc_only), .irq(irq));
	wwd_partner i_far (.pclk(pclk), .presetn(presetn), .wdt_fault(wdt_fault),
		.fault_proc_only(fault_proc_only), .slow_clk_en(slow_clk_en), .proc_rsts(proc_rsts),
		.sys_rsts(sys_rsts));
	// 50 MHz clock
	initial forever #10 pclk = ~pclk;
	////////////////////////////////////////////////////////////////
	task final_report();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : final_report
	task chk(input string n, input logic [31:0] e, input logic [31:0] s);
		check_count++;
		if (s !== e) begin
			$display("[ERR] %s exp %h got %h", n, e, s);
			miscompares++;
		end
	endtask : chk
	// One APB transfer; request held until pready is seen high
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
		@(posedge pclk);
		penable <= 1'h1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		rd = prdata;
		err = pslverr;
		{psel, penable} <= 2'h0;
		if (k >= 20) begin
			miscompares++;
			final_report();
		end
	endtask : apb
	// Halted phase keeps reload; run phase of ~300 pulses gives two ticks
	function logic [31:0] exp_cnt(input logic [31:0] md);
		return md[15] ? {20'h0, md[11:0]} : {20'h0, md[11:0] - 12'h2};
	endfunction : exp_cnt
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'h1;
		apb(0, wwd_pkg::OFS_MODE, 0); chk("mode", 32'h3fff2fff, rd);
		apb(0, wwd_pkg::OFS_COUNT, 0); chk("count", 32'hfff, rd);
		m = 32'h0001_7003;
		apb(1, wwd_pkg::OFS_MODE, m);
		apb(1, wwd_pkg::OFS_MODE, 32'h0);
		chk("scope proc", 1, fault_proc_only);
		apb(0, wwd_pkg::OFS_MODE, 0); chk("mode once", m, rd);
		i = $random(seed);
		apb(1, wwd_pkg::OFS_RESTART, {(i[7:0] == 8'ha5) ? 8'h5a : i[7:0], 24'h1});
		apb(1, wwd_pkg::OFS_RESTART, {8'ha5, i[23:1], 1'b0});
		apb(0, wwd_pkg::OFS_STATUS, 0); chk("no err", 32'h0, rd);
		apb(1, wwd_pkg::OFS_RESTART, 32'ha500_0001);
		@(negedge pclk);
		chk("fault irq", 1, fault_irq);
		chk("fault", 1, wdt_fault);
		apb(0, wwd_pkg::OFS_STATUS, 0); chk("err flag", 32'h2, rd);
		// The reset controller counts one edge after the fault line rises
		chk("proc rst", 1, proc_rsts);
		@(negedge pclk); chk("cleared", 0, {fault_irq, wdt_fault});
		i = 0;
		do begin
			apb(0, wwd_pkg::OFS_COUNT, 0);
			i++;
		end while (rd > 1 && i < 400);
		chk("window reached", 1, rd <= 1);
		apb(1, wwd_pkg::OFS_RESTART, 32'ha500_0001);
		apb(0, wwd_pkg::OFS_COUNT, 0); chk("reload", 32'h3, rd);
		apb(0, wwd_pkg::OFS_STATUS, 0); chk("in window", 0, rd);
		// The earlier window error is still pending; clear it so only underflow can fire
		apb(1, wwd_pkg::OFS_IRQ_STAT, 32'h3);
		apb(1, wwd_pkg::OFS_IRQ_MASK, 32'h3);
		for (i = 0; i < 3000 && irq !== 1'b1; i++) @(negedge pclk);
		chk("irq seen", 1, irq);
		apb(0, wwd_pkg::OFS_STATUS, 0); chk("unf flag", 32'h1, rd);
		apb(1, wwd_pkg::OFS_IRQ_MASK, 32'h0);
		@(negedge pclk); chk("masked", 0, irq);
		apb(1, wwd_pkg::OFS_IRQ_STAT, 32'h3);
		apb(1, wwd_pkg::OFS_IRQ_MASK, 32'h3);
		@(negedge pclk); chk("w1c", 0, irq);
		apb(0, 12'h020, 0); chk("unmapped", 1, err);
		$display("test basic done");
		// Each halting source, then disable, after a fresh reset
		for (int c = 0; c < 3; c++) begin
			presetn <= 1'h0;
			repeat (2) @(posedge pclk);
			presetn <= 1'h1;
			apb(1, wwd_pkg::OFS_MODE, cfg[c]);
			// Only the source under test is active, so a crossed halt input shows
			debug_state <= (c == 0);
			idle_state <= (c == 1);
			repeat (1100) @(posedge pclk);
			apb(0, wwd_pkg::OFS_COUNT, 0); chk("held", 32'h3, rd);
			{debug_state, idle_state} <= 2'h0;
			repeat (600) @(posedge pclk);
			apb(0, wwd_pkg::OFS_COUNT, 0); chk("resumed", exp_cnt(cfg[c]), rd);
			apb(0, wwd_pkg::OFS_STATUS, 0); chk("no unf", 0, rd);
			$display("test cfg %0d done", c);
		end
		// Full-scope request with the interrupt off; a partial strobe spends no write
		presetn <= 1'h0;
		repeat (2) @(posedge pclk);
		presetn <= 1'h1;
		pstrb <= 4'h1;
		apb(1, wwd_pkg::OFS_MODE, 32'h0000_2003);
		pstrb <= 4'hf;
		apb(0, wwd_pkg::OFS_MODE, 0); chk("strobe", 32'h3fff2fff, rd);
		apb(1, wwd_pkg::OFS_MODE, 32'h0000_2003);
		apb(1, wwd_pkg::OFS_RESTART, 32'ha500_0001);
		@(negedge pclk);
		chk("no irq", 0, fault_irq);
		chk("fault all", 1, wdt_fault);
		chk("scope all", 0, fault_proc_only);
		apb(0, wwd_pkg::OFS_STATUS, 0); chk("err all", 32'h2, rd);
		chk("sys rst", 1, sys_rsts);
		chk("no proc", 0, proc_rsts);
		$display("test scope done");
		final_report();
	end
endmodule : wwd_top_bench
`default_nettype wire
